/* hw/iqs_pkg.sv */
// Package with the constants and carriers of the interrupt queue setup block.
package iqs_pkg;

  // ==========================================================
  // Bus and register map
  // ==========================================================
  localparam int unsigned IQS_AW = 8;
  localparam int unsigned IQS_DW = 32;
  localparam logic [7:0] IQS_OFS_ACCESS = 8'hE0;
  localparam logic [7:0] IQS_OFS_BASE   = 8'hE4;
  localparam logic [7:0] IQS_OFS_LENGTH = 8'hE8;
  localparam logic [7:0] IQS_OFS_MASK   = 8'hEC;
  localparam logic [31:0] IQS_RST_WORD  = 32'h0000_0000;

  // ==========================================================
  // Field positions of the setup access register
  // ==========================================================
  localparam int unsigned IQS_Q_LSB       = 0;
  localparam int unsigned IQS_Q_W         = 4;
  localparam int unsigned IQS_BIT_CBASE   = 16;
  localparam int unsigned IQS_BIT_CSIZE   = 17;
  localparam int unsigned IQS_BIT_CMASK   = 18;
  localparam int unsigned IQS_BIT_RDBACK  = 19;

  // ==========================================================
  // Field positions of the staging registers
  // ==========================================================
  localparam int unsigned IQS_BASE_LSB = 2;
  localparam int unsigned IQS_BASE_W   = 30;
  localparam int unsigned IQS_CODE_W   = 8;
  localparam int unsigned IQS_MASK_W   = 32;

  // ==========================================================
  // Queue set and sizing
  // ==========================================================
  localparam int unsigned IQS_NQ = 9;
  localparam logic [3:0]  IQS_CMD_Q = 4'h8;
  localparam logic [3:0]  IQS_HP_Q  = 4'h7;
  localparam int unsigned IQS_SIZE_W = 13;
  localparam int unsigned IQS_PTR_W  = 12;
  localparam logic [12:0] IQS_WORDS_PER_CODE = 13'h0010;
  localparam logic [12:0] IQS_MAX_CH_WORDS   = 13'h0FFC;
  localparam logic [12:0] IQS_CMD_WORDS      = 13'h0200;
  localparam logic [12:0] IQS_ONE_WORD       = 13'h0001;
  localparam logic [7:0]  IQS_CODE_ONE_WORD  = 8'hFF;

  // Live setup of one queue.
  typedef struct packed {
    logic [29:0] base;
    logic [7:0]  code;
    logic [12:0] size;
    logic [31:0] mask;
    logic        high_prio;
  } iqs_qcfg_t;

  // One command written to the setup access register.
  typedef struct packed {
    logic [3:0] q;
    logic       commit_base;
    logic       commit_size;
    logic       commit_mask;
    logic       readback;
  } iqs_cmd_t;

endpackage

/* hw/iqs_len_calc.sv */
// Length code to queue size in words.
`timescale 1ns/100ps
module iqs_len_calc
  import iqs_pkg::*;
(
  input  wire logic [7:0]  code,
  input  wire logic        is_cmd,
  output logic      [12:0] size
);

  logic [12:0] scaled;

  // Channel size is code plus one times sixteen, capped at the maximum.
  always_comb begin
    scaled = 13'({5'h0, code} + 13'h0001) * IQS_WORDS_PER_CODE;
    if (is_cmd) begin
      size = IQS_CMD_WORDS;
    end else if (code == IQS_CODE_ONE_WORD) begin
      size = IQS_ONE_WORD;
    end else if (scaled > IQS_MAX_CH_WORDS) begin
      size = IQS_MAX_CH_WORDS;
    end else begin
      size = scaled;
    end
  end

endmodule

/* hw/iqs_qtable.sv */
// Per-queue setup storage and vector write pointers.
`timescale 1ns/100ps
module iqs_qtable
  import iqs_pkg::*;
#(
  parameter int unsigned NQ = IQS_NQ
)(
  input  wire logic                  clock,
  input  wire logic                  resetn,
  input  wire logic [3:0]            sel,
  input  wire logic                  set_base,
  input  wire logic                  set_len,
  input  wire logic                  set_mask,
  input  wire logic [29:0]           base_in,
  input  wire logic [7:0]            code_in,
  input  wire logic [12:0]           size_in,
  input  wire logic [31:0]           mask_in,
  input  wire logic [NQ-1:0]         push,
  output iqs_qcfg_t [NQ-1:0]         cfg,
  output logic [NQ-1:0][11:0]        ptr
);

  genvar g;
  generate
    for (g = 0; g < NQ; g++) begin : g_q
      localparam logic [3:0] IDX = 4'(g);
      localparam logic [12:0] RST_SIZE =
        (IDX == IQS_CMD_Q) ? IQS_CMD_WORDS : IQS_WORDS_PER_CODE;
      iqs_qcfg_t   cfg_r;
      iqs_qcfg_t   cfg_nxt;
      logic [11:0] ptr_r;
      logic [11:0] ptr_nxt;
      logic        hit;
      logic [12:0] ptr_inc;

      // Load committed values and step or restart the write pointer.
      always_comb begin
        hit     = (sel == IDX);
        ptr_inc = 13'({1'b0, ptr_r} + 13'h0001);
        cfg_nxt = cfg_r;
        ptr_nxt = ptr_r;
        if (hit && set_base) begin
          cfg_nxt.base = base_in;
        end
        if (hit && set_len) begin
          cfg_nxt.code = code_in;
          cfg_nxt.size = size_in;
        end
        if (hit && set_mask) begin
          cfg_nxt.mask = mask_in;
        end
        if (hit && (set_base || set_len)) begin
          ptr_nxt = '0;
        end else if (push[g]) begin
          ptr_nxt = (ptr_inc >= cfg_r.size) ? '0 : ptr_inc[11:0];
        end
      end

      // Register the queue state.
      always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
          cfg_r <= '{base: '0, code: '0, size: RST_SIZE, mask: '0,
                     high_prio: (IDX == IQS_HP_Q)};
          ptr_r <= '0;
        end else begin
          cfg_r <= cfg_nxt;
          ptr_r <= ptr_nxt;
        end
      end

      assign cfg[g] = cfg_r;
      assign ptr[g] = ptr_r;
    end
  endgenerate

endmodule

/* hw/iqs_ctrl.sv */
// Interrupt queue setup: staging registers, commits and readback.
//
// Contract
// - Queue index selects the committed queue; 0 to 7 channel, 8 command.
// - Queue 7 is the high-priority queue by default.
// - Base, size and mask commits in one write apply together.
// - Command queue length is fixed at 512 words.
// - Staged base serves all channel queues and the command queue.
// - Base is word aligned; bits 1 and 0 are zero.
// - After a base change the next vector goes to the first location.
// - Length code applies to the channel queues only.
// - Channel size is (code+1)*16 words, capped at 4092.
// - Length code 255 gives a one word queue.
// - After a length change the next vector goes to the first location.
// - Readback copies the selected queue's setup into staging registers.
//
// Operation
// Software writes the base, length and mask staging registers first.
// A write to the setup access register then names a queue in its low
// four bits and carries up to three commit bits and a readback bit.
// Every commit bit that is set copies its staged value into the named
// queue on the clock edge that takes the write, so a base, a length
// and a mask committed together land in the same cycle.
// The staging registers are not cleared by a commit. One staged value
// can therefore be committed to several queues in turn, with one
// access write per queue and no rewrite of the staging register.
//
// Refusals
// A queue index above eight matches no queue and every commit bit in
// that write is dropped; the index still reads back from the access
// register.
// A length commit to the command queue is dropped, so that queue keeps
// its fixed size whatever code is staged.
// A mask commit to the command queue or to the high-priority queue is
// dropped as well. Software must not rely on either being stored.
// A readback bit written together with any commit bit is ignored and
// the commits act alone. Mixing the two would let the staging
// registers be overwritten in the same cycle that they are consumed.
//
// Readback
// A readback copies the live base, length code and mask of the named
// queue into the staging registers. The stored length code is copied,
// not the derived size, so the command queue reads back a code of zero.
// A readback of an index above eight loads zeros into all three.
// A readback overwrites whatever software had staged, so fresh staging
// writes must follow it before the next commit.
//
// Vector pointers
// Each queue keeps a word pointer that the vector writer advances by
// one per stored vector and that wraps to zero at the queue size.
// A base or length commit to a queue restarts its pointer at zero,
// even in a cycle in which the writer stores a vector to that queue.
// A length code of 255 is taken as a one-word queue, which makes every
// vector land in the first location.
// Read data stand for exactly one cycle after the read strobe.
//
// Added by the designer: the plain strobed port.
`timescale 1ns/100ps
module iqs_ctrl
  import iqs_pkg::*;
#(
  parameter int unsigned NQ = IQS_NQ
)(
  input  wire logic                  clock,
  input  wire logic                  resetn,
  input  wire logic [7:0]            reg_addr,
  input  wire logic [31:0]           reg_wdata,
  input  wire logic                  reg_wr,
  input  wire logic                  reg_rd,
  output logic      [31:0]           reg_rdata,
  input  wire logic [NQ-1:0]         vec_push,
  output logic      [NQ-1:0][31:0]   vec_addr,
  output iqs_qcfg_t [NQ-1:0]         q_cfg,
  output logic      [3:0]            hp_queue
);

  // ==========================================================
  // Declarations
  // ==========================================================
  logic [29:0]          base_r;
  logic [29:0]          base_nxt;
  logic [7:0]           code_r;
  logic [7:0]           code_nxt;
  logic [31:0]          mask_r;
  logic [31:0]          mask_nxt;
  logic [3:0]           q_r;
  logic [3:0]           q_nxt;
  logic [31:0]          rdata_r;
  logic [31:0]          rdata_nxt;

  logic                 wr_access;
  logic                 wr_base;
  logic                 wr_length;
  logic                 wr_mask;
  iqs_cmd_t             cmd;
  logic                 q_valid;
  logic                 is_cmd_q;
  logic                 do_base;
  logic                 do_size;
  logic                 do_mask;
  logic                 do_readback;
  logic [12:0]          staged_size;
  iqs_qcfg_t            sel_cfg;
  logic [NQ-1:0][11:0]  wr_ptr;

  // ==========================================================
  // Register decode
  // ==========================================================

  // One strobe per cycle; each write picks at most one register.
  assign wr_access = reg_wr && (reg_addr == IQS_OFS_ACCESS);
  assign wr_base   = reg_wr && (reg_addr == IQS_OFS_BASE);
  assign wr_length = reg_wr && (reg_addr == IQS_OFS_LENGTH);
  assign wr_mask   = reg_wr && (reg_addr == IQS_OFS_MASK);

  // Split the access word into its command fields.
  always_comb begin
    cmd.q           = reg_wdata[IQS_Q_LSB +: IQS_Q_W];
    cmd.commit_base = reg_wdata[IQS_BIT_CBASE];
    cmd.commit_size = reg_wdata[IQS_BIT_CSIZE];
    cmd.commit_mask = reg_wdata[IQS_BIT_CMASK];
    cmd.readback    = reg_wdata[IQS_BIT_RDBACK];
  end

  // ==========================================================
  // Commit qualification
  // ==========================================================

  assign q_valid  = (cmd.q <= IQS_CMD_Q);
  assign is_cmd_q = (cmd.q == IQS_CMD_Q);

  assign do_base = wr_access && q_valid && cmd.commit_base;

  assign do_size = wr_access && q_valid && !is_cmd_q
                   && cmd.commit_size;

  assign do_mask = wr_access && q_valid && !is_cmd_q
                   && (cmd.q != IQS_HP_Q) && cmd.commit_mask;

  // A readback that comes with any commit is dropped; commits win.
  assign do_readback = wr_access && cmd.readback
                       && !(cmd.commit_base || cmd.commit_size
                            || cmd.commit_mask);

  // ==========================================================
  // Length sizing
  // ==========================================================

  iqs_len_calc u_len (
    .code   (code_r),
    .is_cmd (is_cmd_q),
    .size   (staged_size)
  );

  // ==========================================================
  // Queue table
  // ==========================================================

  iqs_qtable #(
    .NQ (NQ)
  ) u_table (
    .clock    (clock),
    .resetn   (resetn),
    .sel      (cmd.q),
    .set_base (do_base),
    .set_len  (do_size),
    .set_mask (do_mask),
    .base_in  (base_r),
    .code_in  (code_r),
    .size_in  (staged_size),
    .mask_in  (mask_r),
    .push     (vec_push),
    .cfg      (q_cfg),
    .ptr      (wr_ptr)
  );

  // Current setup of the queue named by the command, for readback.
  always_comb begin
    sel_cfg = '0;
    for (int i = 0; i < NQ; i++) begin
      if (cmd.q == 4'(i)) begin
        sel_cfg = q_cfg[i];
      end
    end
  end

  // ==========================================================
  // Staging registers
  // ==========================================================

  always_comb begin
    base_nxt = base_r;
    code_nxt = code_r;
    mask_nxt = mask_r;
    q_nxt    = q_r;
    if (wr_base) begin
      base_nxt = reg_wdata[IQS_BASE_LSB +: IQS_BASE_W];
    end
    if (wr_length) begin
      code_nxt = reg_wdata[IQS_CODE_W-1:0];
    end
    if (wr_mask) begin
      mask_nxt = reg_wdata[IQS_MASK_W-1:0];
    end
    if (wr_access) begin
      q_nxt = cmd.q;
    end
    if (do_readback) begin
      base_nxt = sel_cfg.base;
      code_nxt = sel_cfg.code;
      mask_nxt = sel_cfg.mask;
    end
  end

  // Register the staging values and the last selected queue.
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      base_r <= '0;
      code_r <= '0;
      mask_r <= '0;
      q_r    <= '0;
    end else begin
      base_r <= base_nxt;
      code_r <= code_nxt;
      mask_r <= mask_nxt;
      q_r    <= q_nxt;
    end
  end

  // ==========================================================
  // Read data
  // ==========================================================

  // Read data stand for one cycle after the strobe and are zero else.
  always_comb begin
    rdata_nxt = IQS_RST_WORD;
    if (reg_rd) begin
      unique case (reg_addr)
        IQS_OFS_ACCESS: begin
          // Commit and readback bits act once and read as zero.
          rdata_nxt[IQS_Q_LSB +: IQS_Q_W] = q_r;
        end
        IQS_OFS_BASE: begin
          rdata_nxt[IQS_BASE_LSB +: IQS_BASE_W] = base_r;
        end
        IQS_OFS_LENGTH: begin
          rdata_nxt[IQS_CODE_W-1:0] = code_r;
        end
        IQS_OFS_MASK: begin
          rdata_nxt[IQS_MASK_W-1:0] = mask_r;
        end
        default: begin
          rdata_nxt = IQS_RST_WORD;
        end
      endcase
    end
  end

  // Register the read answer.
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      rdata_r <= IQS_RST_WORD;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  assign reg_rdata = rdata_r;

  // ==========================================================
  // Vector write addresses
  // ==========================================================

  // Byte address of the next vector slot of each queue.
  genvar g;
  generate
    for (g = 0; g < NQ; g++) begin : g_addr
      logic [29:0] word;
      assign word = q_cfg[g].base + {18'h0, wr_ptr[g]};
      assign vec_addr[g] = {word, 2'b00};
    end
  endgenerate

  assign hp_queue = IQS_HP_Q;

endmodule

/* tb/iqs_ctrl_asserts.sv */
// Concurrent checks on the ports of the interrupt queue setup block.
`timescale 1ns/100ps
module iqs_ctrl_asserts
  import iqs_pkg::*;
#(
  parameter int unsigned NQ = IQS_NQ
)(
  input wire logic                  clock,
  input wire logic                  resetn,
  input wire logic [7:0]            reg_addr,
  input wire logic [31:0]           reg_wdata,
  input wire logic                  reg_wr,
  input wire logic                  reg_rd,
  input wire logic [31:0]           reg_rdata,
  input wire logic [NQ-1:0]         vec_push,
  input wire logic [NQ-1:0][31:0]   vec_addr,
  input wire iqs_qcfg_t [NQ-1:0]    q_cfg,
  input wire logic [3:0]            hp_queue
);
  // ==========================================================
  // Checks
  // ==========================================================
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);
  logic       acc_wr;
  logic [3:0] qs;
  // A write to the setup access register and the queue it names.
  assign acc_wr = reg_wr && reg_addr == IQS_OFS_ACCESS;
  assign qs     = reg_wdata[3:0];

  a_rdata_slot: assert property (
    reg_rdata != 32'h0 |-> $past(reg_rd)) else $error("read data out of slot");
  a_hp_index: assert property (
    hp_queue == IQS_HP_Q && q_cfg[7].high_prio && !q_cfg[0].high_prio)
    else $error("high priority queue wrong");
  a_cmd_fixed: assert property (
    q_cfg[8].size == IQS_CMD_WORDS) else $error("command queue size wrong");
  a_ch_size: assert property (
    q_cfg[0].size == ((q_cfg[0].code == 8'hFF) ? 13'h0001 :
      ({5'h00, q_cfg[0].code} + 13'h0001) * 13'h0010))
    else $error("channel size wrong");
  a_base_restart: assert property (
    acc_wr && reg_wdata[16] && qs <= 4'h8 |=>
      vec_addr[$past(qs)] == {q_cfg[$past(qs)].base, 2'b00})
    else $error("base commit did not restart queue");
  a_len_restart: assert property (
    acc_wr && reg_wdata[17] && qs < 4'h8 |=>
      vec_addr[$past(qs)] == {q_cfg[$past(qs)].base, 2'b00})
    else $error("length commit did not restart queue");
  a_mask_refused: assert property (
    acc_wr && reg_wdata[18] && qs >= 4'h7 |=>
      $stable(q_cfg[7].mask) && $stable(q_cfg[8].mask))
    else $error("mask taken by queue 7 or 8");
  a_cmd_code: assert property (
    acc_wr && reg_wdata[17] && qs == 4'h8 |=> $stable(q_cfg[8].code))
    else $error("length taken by command queue");
  a_push_step: assert property (
    vec_push[2] && !reg_wr |=> vec_addr[2] == $past(vec_addr[2]) + 32'h4
      || vec_addr[2] == {q_cfg[2].base, 2'b00})
    else $error("vector pointer step wrong");
endmodule

bind iqs_ctrl iqs_ctrl_asserts #(.NQ(NQ)) u_asserts (.clock(clock),
  .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .vec_push(vec_push), .vec_addr(vec_addr), .q_cfg(q_cfg),
  .hp_queue(hp_queue));

/* tb/iqs_vec_writer.sv */
// Model of the vector writer that stores vectors into the queues.
`timescale 1ns/100ps
module iqs_vec_writer
  import iqs_pkg::*;
#(
  parameter int unsigned NQ = IQS_NQ
)(
  input  wire logic          clock,
  input  wire logic          resetn,
  input  wire logic          go,
  input  wire logic [3:0]    q,
  input  wire logic [3:0]    lag,
  output logic      [NQ-1:0] vec_push
);
  // ==========================================================
  // Vector store
  // ==========================================================
  logic [3:0] wait_r;
  logic [3:0] q_r;
  logic       busy_r;
  // Take a request, wait its lag, then store one vector word.
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      vec_push <= '0;
      busy_r   <= 1'b0;
      wait_r   <= 4'h0;
      q_r      <= 4'h0;
    end else begin
      if (go) begin
        vec_push <= '0;
        busy_r   <= 1'b1;
        wait_r   <= lag;
        q_r      <= q;
      end else if (busy_r && wait_r != 4'h0) begin
        vec_push <= '0;
        wait_r   <= wait_r - 4'h1;
      end else if (busy_r) begin
        busy_r   <= 1'b0;
        vec_push <= NQ'(1) << q_r;
      end else begin
        vec_push <= '0;
      end
    end
  end
endmodule

/* tb/iqs_ctrl_tb.sv */
// Self-checking bench of the interrupt queue setup block.
`timescale 1ns/100ps
module iqs_ctrl_tb
  import iqs_pkg::*;
;
  logic                    clock;
  logic                    resetn;
  logic [7:0]              reg_addr;
  logic [31:0]             reg_wdata;
  logic                    reg_wr;
  logic                    reg_rd;
  logic [31:0]             reg_rdata;
  logic [IQS_NQ-1:0]       vec_push;
  logic [IQS_NQ-1:0][31:0] vec_addr;
  iqs_qcfg_t [IQS_NQ-1:0]  q_cfg;
  logic [3:0]              hp_queue;
  logic                    go;
  logic [3:0]              go_q;
  logic [3:0]              go_lag;
  int                      n_errors = 0;
  int                      checks = 0;

  // ==========================================================
  // Instances, clock and watchdog
  // ==========================================================
  iqs_ctrl dut (.clock(clock), .resetn(resetn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .vec_push(vec_push), .vec_addr(vec_addr),
    .q_cfg(q_cfg), .hp_queue(hp_queue));
  iqs_vec_writer partner (.clock(clock), .resetn(resetn), .go(go),
    .q(go_q), .lag(go_lag), .vec_push(vec_push));
  // Free running 50 MHz clock.
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  // Cut a hang short well past the expected run time.
  initial begin
    #200000;
    n_errors++;
    give_verdict;
  end

  task automatic give_verdict;
    $display("checks %0d errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clock);
    reg_wr    <= 1'b0;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clock);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clock);
    reg_rd   <= 1'b0;
    #1;
    chk(reg_rdata, exp);
  endtask
  // Bits: 0 base, 1 size, 2 mask, 3 readback.
  task automatic commit(input logic [3:0] q, input logic [3:0] b);
    wr(IQS_OFS_ACCESS, {12'h000, b, 12'h000, q});
    #1;
  endtask
  task automatic push(input logic [3:0] q, input logic [3:0] lag);
    @(posedge clock);
    go     <= 1'b1;
    go_q   <= q;
    go_lag <= lag;
    @(posedge clock);
    go <= 1'b0;
    repeat (20) begin
      @(posedge clock);
      if (vec_push[q] === 1'b1) break;
    end
    #1;
  endtask

  // ==========================================================
  // Scenarios
  // ==========================================================
  task automatic t_reset;
    rdc(IQS_OFS_BASE, 32'h0);
    rdc(IQS_OFS_LENGTH, 32'h0);
    rdc(IQS_OFS_MASK, 32'h0);
    chk({28'h0, hp_queue}, 32'h7);
    chk({19'h0, q_cfg[8].size}, 32'h200);
    chk({19'h0, q_cfg[3].size}, 32'h10);
    $display("test reset done");
  endtask
  task automatic t_fields;
    wr(IQS_OFS_BASE, 32'hFFFF_FFFF);
    wr(IQS_OFS_LENGTH, 32'hFFFF_FFFF);
    wr(IQS_OFS_MASK, 32'hFFFF_FFFF);
    wr(8'hF0, 32'hFFFF_FFFF);
    rdc(IQS_OFS_BASE, 32'hFFFF_FFFC);
    rdc(IQS_OFS_LENGTH, 32'h0000_00FF);
    rdc(IQS_OFS_MASK, 32'hFFFF_FFFF);
    rdc(8'hF0, 32'h0);
    $display("test fields done");
  endtask
  task automatic t_every_queue;
    logic [31:0] e;
    for (int i = 0; i < 9; i++) begin
      wr(IQS_OFS_BASE, 32'h1000_0000 + 32'(i) * 32'h100);
      commit(4'(i), 4'h1);
    end
    for (int i = 0; i < 9; i++) begin
      e = 32'h1000_0000 + 32'(i) * 32'h100;
      chk({2'h0, q_cfg[i].base}, e >> 2);
      chk(vec_addr[i], e);
    end
    $display("test every queue done");
  endtask
  task automatic t_all_three;
    wr(IQS_OFS_BASE, 32'h2000_0040);
    wr(IQS_OFS_LENGTH, 32'h3);
    wr(IQS_OFS_MASK, 32'hA5A5_0F0F);
    commit(4'h2, 4'h7);
    chk(vec_addr[2], 32'h2000_0040);
    chk({24'h0, q_cfg[2].code}, 32'h3);
    chk({19'h0, q_cfg[2].size}, 32'h40);
    chk(q_cfg[2].mask, 32'hA5A5_0F0F);
    commit(4'h5, 4'h2);
    chk({19'h0, q_cfg[5].size}, 32'h40);
    commit(4'h8, 4'h2);
    chk({19'h0, q_cfg[8].size}, 32'h200);
    $display("test commit all done");
  endtask
  task automatic t_pointer;
    push(4'h2, 4'h0);
    chk(vec_addr[2], 32'h2000_0044);
    push(4'h2, 4'h3);
    chk(vec_addr[2], 32'h2000_0048);
    commit(4'h2, 4'h2);
    chk(vec_addr[2], 32'h2000_0040);
    push(4'h2, 4'h0);
    commit(4'h2, 4'h1);
    chk(vec_addr[2], 32'h2000_0040);
    wr(IQS_OFS_LENGTH, 32'hFF);
    commit(4'h0, 4'h2);
    chk({19'h0, q_cfg[0].size}, 32'h1);
    push(4'h0, 4'h1);
    chk(vec_addr[0], 32'h1000_0000);
    $display("test pointer done");
  endtask
  task automatic t_readback;
    wr(IQS_OFS_BASE, 32'h0);
    wr(IQS_OFS_MASK, 32'h0);
    commit(4'h2, 4'h8);
    rdc(IQS_OFS_BASE, 32'h2000_0040);
    rdc(IQS_OFS_LENGTH, 32'h3);
    rdc(IQS_OFS_MASK, 32'hA5A5_0F0F);
    $display("test readback done");
  endtask
  task automatic t_refused;
    wr(IQS_OFS_MASK, 32'h1234_5678);
    commit(4'h7, 4'h4);
    chk(q_cfg[7].mask, 32'h0);
    commit(4'h8, 4'h6);
    chk(q_cfg[8].mask, 32'h0);
    chk({19'h0, q_cfg[8].size}, 32'h200);
    commit(4'h9, 4'h1);
    rdc(IQS_OFS_ACCESS, 32'h9);
    chk(vec_addr[8], 32'h1000_0800);
    commit(4'h2, 4'hC);
    rdc(IQS_OFS_MASK, 32'h1234_5678);
    chk(q_cfg[2].mask, 32'h1234_5678);
    commit(4'hA, 4'h8);
    rdc(IQS_OFS_BASE, 32'h0);
    $display("test refused done");
  endtask
  task automatic t_reset_again;
    @(posedge clock);
    resetn <= 1'b0;
    repeat (2) @(posedge clock);
    resetn <= 1'b1;
    #1;
    chk(vec_addr[2], 32'h0);
    chk({19'h0, q_cfg[0].size}, 32'h10);
    chk({31'h0, q_cfg[7].high_prio}, 32'h1);
    rdc(IQS_OFS_MASK, 32'h0);
    $display("test reset again done");
  endtask

  // Reset, then the scenarios in order.
  initial begin
    resetn    = 1'b0;
    reg_addr  = 8'h00;
    reg_wdata = 32'h0;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    go        = 1'b0;
    go_q      = 4'h0;
    go_lag    = 4'h0;
    repeat (16) @(posedge clock);
    resetn <= 1'b1;
    t_reset;
    t_fields;
    t_every_queue;
    t_all_three;
    t_pointer;
    t_readback;
    t_refused;
    t_reset_again;
    give_verdict;
  end
endmodule
